// ---- pkg/sps_regs.vh ----
// constants for the slave port forwarding and state machine block
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// state codes reported on o_state; the copy code is shown there as preop
`define SPS_ST_INIT    4'h1
`define SPS_ST_PREOP   4'h2
`define SPS_ST_BOOT    4'h3
`define SPS_ST_COPY    4'h5
`define SPS_ST_SAFEOP  4'h4
`define SPS_ST_OP      4'h8

// traffic class carried in the first byte of a frame
`define SPS_TY_MBX     8'h01
`define SPS_TY_FILE    8'h02
`define SPS_TY_OBJ     8'h03
`define SPS_TY_PD      8'h04

// byte positions inside a frame
`define SPS_POS_TYPE   6'h00
`define SPS_POS_PD     6'h01
`define SPS_POS_MAX    6'h3f
`define SPS_POS_ONE    6'h01

// stream sources and transmit ports
`define SPS_SRC_PROC   2'h0
`define SPS_SRC_R1     2'h1
`define SPS_SRC_R2     2'h2
`define SPS_SRC_NONE   2'h3
`define SPS_TX_P0      2'h0
`define SPS_TX_P1      2'h1
`define SPS_TX_P2      2'h2

// reset and safe values, fifo depth and address width
`define SPS_SAFE_OUT   8'h00
`define SPS_FIFO_DEPTH 32
`define SPS_FIFO_AW    5

`endif

// ---- src/sps_fifo.v ----
// frame byte fifo between the processing unit and the port router
`include "sps_regs.vh"
`default_nettype none

module sps_fifo #(
  parameter W     = 9,
  parameter DEPTH = `SPS_FIFO_DEPTH,
  parameter AW    = `SPS_FIFO_AW
) (
  input  wire         i_clk_sys,
  input  wire         i_rst,
  input  wire         i_in_valid,
  input  wire [W-1:0] i_in_data,
  output wire         o_in_ready,
  output wire         o_out_valid,
  output wire [W-1:0] o_out_data,
  input  wire         i_out_ready
);

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  // full and empty come straight from the occupancy count
  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // storage has no reset, only the pointers and the count do
  always @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  // pointers wrap; depth must be a power of two
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/sps_top.v ----
// port forwarding ring, frame processing and slave state machine
`include "sps_regs.vh"
`default_nettype none

// Notes on behaviour
// - ports 1 and 2 are each opened or closed on their own, by their link state; port 0 stays open.
// - frames from the network input on port 0 enter the processing unit.
// - processed frames go out port 1 only while port 1 reports link.
// - frames back on port 1 go out port 2 only while it has link.
// - frames arriving on port 2 are sent out port 0.
// - datagram contents are touched only on the port 0 processing path.
// - state machine has init, preop, safeop, operational and boot states.
// - reset enters init; no mailbox and no process data there.
// - init to preop is taken only when mailbox setup is correct.
// - preop allows mailbox traffic and blocks process data.
// - preop to safeop checks process data setup and used clock setup.
// - inputs are copied to the memory image before safeop is acknowledged.
// - safeop allows all but object dictionary traffic, refreshes inputs, holds outputs safe while the watchdog is on.
// - watchdog on forces safe outputs in safeop; watchdog off lets safeop drive them.
// - operational applies master output data; all traffic but object dictionary enabled.
// - boot is entered only from init.
// - boot accepts file transfer mailbox only, nothing else.
// - the object dictionary mailbox protocol is never served.
module sps_top #(
  parameter DW = 8
) (
  input  wire          i_clk_sys,
  input  wire          i_rst,
  input  wire          i_p0_rx_valid,
  input  wire [DW-1:0] i_p0_rx_data,
  input  wire          i_p0_rx_last,
  output wire          o_p0_rx_ready,
  input  wire          i_p1_rx_valid,
  input  wire [DW-1:0] i_p1_rx_data,
  input  wire          i_p1_rx_last,
  output wire          o_p1_rx_ready,
  input  wire          i_p2_rx_valid,
  input  wire [DW-1:0] i_p2_rx_data,
  input  wire          i_p2_rx_last,
  output wire          o_p2_rx_ready,
  output wire          o_p0_tx_valid,
  output wire [DW-1:0] o_p0_tx_data,
  output wire          o_p0_tx_last,
  input  wire          i_p0_tx_ready,
  output wire          o_p1_tx_valid,
  output wire [DW-1:0] o_p1_tx_data,
  output wire          o_p1_tx_last,
  input  wire          i_p1_tx_ready,
  output wire          o_p2_tx_valid,
  output wire [DW-1:0] o_p2_tx_data,
  output wire          o_p2_tx_last,
  input  wire          i_p2_tx_ready,
  input  wire          i_p1_link,
  input  wire          i_p2_link,
  input  wire          i_req_valid,
  input  wire [3:0]    i_req_state,
  input  wire          i_mbx_cfg_ok,
  input  wire          i_pd_cfg_ok,
  input  wire          i_dc_used,
  input  wire          i_dc_cfg_ok,
  input  wire          i_wdog_en,
  input  wire [DW-1:0] i_inputs,
  output wire [DW-1:0] o_outputs,
  output wire [3:0]    o_state,
  output wire          o_ack,
  output wire          o_refused,
  output wire          o_mbx_en,
  output wire          o_pd_en,
  output wire          o_frame_accept,
  output wire          o_frame_reject
);

  localparam ST_INIT   = `SPS_ST_INIT;
  localparam ST_PREOP  = `SPS_ST_PREOP;
  localparam ST_BOOT   = `SPS_ST_BOOT;
  localparam ST_COPY   = `SPS_ST_COPY;
  localparam ST_SAFEOP = `SPS_ST_SAFEOP;
  localparam ST_OP     = `SPS_ST_OP;

  // closed port forwarding: a frame skips any port without link
  function [1:0] route;
    input [1:0] src;
    input       l1;
    input       l2;
    begin
      case (src)
        `SPS_SRC_PROC: route = l1 ? `SPS_TX_P1 : (l2 ? `SPS_TX_P2 : `SPS_TX_P0);
        `SPS_SRC_R1:   route = l2 ? `SPS_TX_P2 : `SPS_TX_P0;
        default:       route = `SPS_TX_P0;
      endcase
    end
  endfunction

  // link pins come from the phys, so two flops first
  reg  [1:0]    link_s1_q;
  reg  [1:0]    link_s2_q;
  // state machine
  reg  [3:0]    state_q;
  reg  [3:0]    state_d;
  reg           ack_q;
  reg           ack_d;
  reg           ref_q;
  reg           ref_d;
  // process images
  reg  [DW-1:0] in_img_q;
  reg  [DW-1:0] out_img_q;
  reg  [DW-1:0] out_q;
  // frame parsing on port 0
  reg  [5:0]    pos_q;
  reg  [7:0]    type_q;
  reg           acc_q;
  reg           rej_q;
  reg           cls_ok;
  reg  [DW-1:0] proc_data;
  // router
  reg  [2:0]    busy_q;
  reg  [5:0]    dst_q;
  reg  [5:0]    own_q;
  reg  [5:0]    dst_c;
  reg  [5:0]    gsel_c;
  reg  [2:0]    src_rdy_c;
  reg  [2:0]    tx_v_c;
  reg  [3*DW-1:0] tx_d_c;
  reg  [2:0]    tx_l_c;
  integer       s, sq;
  integer       t, tq;

  wire          link1 = link_s2_q[0];
  wire          link2 = link_s2_q[1];
  wire          mbx_ok;
  wire          file_ok;
  wire          pd_ok;
  wire          rx0_take;
  wire [7:0]    rx0_cls;
  wire          fifo_out_v;
  wire [DW:0]   fifo_out_d;
  wire [2:0]    src_v;
  wire [2:0]    src_l;
  wire [3*DW-1:0] src_d;
  wire [2:0]    tx_rdy;

  // two flop synchroniser on the link reports
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      link_s1_q <= 2'h0;
      link_s2_q <= 2'h0;
    end else begin
      link_s1_q <= {i_p2_link, i_p1_link};
      link_s2_q <= link_s1_q;
    end
  end

  // traffic permissions per state; copy phase still counts as preop
  assign mbx_ok  = (state_q == ST_PREOP) | (state_q == ST_COPY) | (state_q == ST_SAFEOP) |
                   (state_q == ST_OP);
  assign file_ok = mbx_ok | (state_q == ST_BOOT);
  assign pd_ok   = (state_q == ST_SAFEOP) | (state_q == ST_OP);

  // next state; requests in the copy phase are refused to keep it atomic
  always @* begin
    state_d = state_q;
    ack_d   = 1'b0;
    ref_d   = 1'b0;
    case (state_q)
      ST_INIT: begin
        if (i_req_valid) begin
          if (i_req_state == ST_INIT) begin
            ack_d = 1'b1;
          end else if (i_req_state == ST_PREOP && i_mbx_cfg_ok) begin
            state_d = ST_PREOP;
            ack_d   = 1'b1;
          end else if (i_req_state == ST_BOOT) begin
            state_d = ST_BOOT;
            ack_d   = 1'b1;
          end else begin
            ref_d = 1'b1;
          end
        end
      end
      ST_BOOT: begin
        if (i_req_valid) begin
          if (i_req_state == ST_INIT || i_req_state == ST_BOOT) begin
            state_d = i_req_state;
            ack_d   = 1'b1;
          end else begin
            ref_d = 1'b1;
          end
        end
      end
      ST_PREOP: begin
        if (i_req_valid) begin
          if (i_req_state == ST_INIT || i_req_state == ST_PREOP) begin
            state_d = i_req_state;
            ack_d   = 1'b1;
          end else if (i_req_state == ST_SAFEOP && i_pd_cfg_ok &&
                       (~i_dc_used | i_dc_cfg_ok)) begin
            state_d = ST_COPY;
          end else begin
            ref_d = 1'b1;
          end
        end
      end
      ST_COPY: begin
        state_d = ST_SAFEOP;
        ack_d   = 1'b1;
        ref_d   = i_req_valid;
      end
      ST_SAFEOP: begin
        if (i_req_valid) begin
          if (i_req_state == ST_INIT || i_req_state == ST_PREOP ||
              i_req_state == ST_SAFEOP || i_req_state == ST_OP) begin
            state_d = i_req_state;
            ack_d   = 1'b1;
          end else begin
            ref_d = 1'b1;
          end
        end
      end
      ST_OP: begin
        if (i_req_valid) begin
          if (i_req_state == ST_INIT || i_req_state == ST_PREOP ||
              i_req_state == ST_SAFEOP || i_req_state == ST_OP) begin
            state_d = i_req_state;
            ack_d   = 1'b1;
          end else begin
            ref_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
  end

  // state registers; power up lands in init
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_INIT;
      ack_q   <= 1'b0;
      ref_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      ack_q   <= ack_d;
      ref_q   <= ref_d;
    end
  end

  // input image: snapshot in copy phase, refreshed every cycle after
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      in_img_q <= `SPS_SAFE_OUT;
    end else if (state_q == ST_COPY || pd_ok) begin
      in_img_q <= i_inputs;
    end
  end

  // outputs follow master data in op, or in safeop with the watchdog off
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      out_q <= `SPS_SAFE_OUT;
    end else if (state_q == ST_OP || (state_q == ST_SAFEOP && ~i_wdog_en)) begin
      out_q <= out_img_q;
    end else begin
      out_q <= `SPS_SAFE_OUT;
    end
  end

  // port 0 frames are parsed and edited on their way into the fifo
  assign rx0_cls = (pos_q == `SPS_POS_TYPE) ? i_p0_rx_data[7:0] : type_q;

  // class permission; object dictionary traffic is never served
  always @* begin
    case (rx0_cls)
      `SPS_TY_MBX:  cls_ok = mbx_ok & (state_q != ST_BOOT);
      `SPS_TY_FILE: cls_ok = file_ok;
      `SPS_TY_OBJ:  cls_ok = 1'b0;
      `SPS_TY_PD:   cls_ok = pd_ok;
      default:      cls_ok = 1'b0;
    endcase
  end

  // only the process data byte is swapped for the input image
  always @* begin
    proc_data = i_p0_rx_data;
    if (pos_q == `SPS_POS_PD && type_q == `SPS_TY_PD && pd_ok) begin
      proc_data = in_img_q;
    end
  end

  // frame byte counter, latched class and accept or reject pulses
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pos_q     <= `SPS_POS_TYPE;
      type_q    <= 8'h00;
      acc_q     <= 1'b0;
      rej_q     <= 1'b0;
      out_img_q <= `SPS_SAFE_OUT;
    end else begin
      acc_q <= 1'b0;
      rej_q <= 1'b0;
      if (rx0_take) begin
        if (i_p0_rx_last) begin
          pos_q <= `SPS_POS_TYPE;
        end else if (pos_q != `SPS_POS_MAX) begin
          pos_q <= pos_q + `SPS_POS_ONE;
        end
        if (pos_q == `SPS_POS_TYPE) begin
          type_q <= i_p0_rx_data[7:0];
          acc_q  <= cls_ok;
          rej_q  <= ~cls_ok;
        end
        // master output byte kept only while process data is allowed
        if (pos_q == `SPS_POS_PD && type_q == `SPS_TY_PD && pd_ok) begin
          out_img_q <= i_p0_rx_data;
        end
      end
    end
  end

  // fifo in the processed path; full fifo stalls port 0 receive
  sps_fifo #(
    .W     (DW + 1),
    .DEPTH (`SPS_FIFO_DEPTH),
    .AW    (`SPS_FIFO_AW)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (i_p0_rx_valid),
    .i_in_data   ({i_p0_rx_last, proc_data}),
    .o_in_ready  (o_p0_rx_ready),
    .o_out_valid (fifo_out_v),
    .o_out_data  (fifo_out_d),
    .i_out_ready (src_rdy_c[0])
  );

  assign rx0_take = i_p0_rx_valid & o_p0_rx_ready;

  // router sources: processed path, port 1 return, port 2 return
  assign src_v  = {i_p2_rx_valid, i_p1_rx_valid, fifo_out_v};
  assign src_l  = {i_p2_rx_last, i_p1_rx_last, fifo_out_d[DW]};
  assign src_d  = {i_p2_rx_data, i_p1_rx_data, fifo_out_d[DW-1:0]};
  assign tx_rdy = {i_p2_tx_ready, i_p1_tx_ready, i_p0_tx_ready};

  // frame-locked arbiter; lowest source wins a free port
  always @* begin
    dst_c     = 6'h00;
    gsel_c    = {3{`SPS_SRC_NONE}};
    src_rdy_c = 3'h0;
    tx_v_c    = 3'h0;
    tx_d_c    = {(3*DW){1'b0}};
    tx_l_c    = 3'h0;
    for (s = 0; s < 3; s = s + 1) begin
      dst_c[2*s +: 2] = busy_q[s] ? dst_q[2*s +: 2] : route(s[1:0], link1, link2);
    end
    for (t = 0; t < 3; t = t + 1) begin
      if (own_q[2*t +: 2] != `SPS_SRC_NONE) begin
        gsel_c[2*t +: 2] = own_q[2*t +: 2];
      end else begin
        for (s = 2; s >= 0; s = s - 1) begin
          if (src_v[s] && dst_c[2*s +: 2] == t[1:0] && ~busy_q[s]) begin
            gsel_c[2*t +: 2] = s[1:0];
          end
        end
      end
      for (s = 0; s < 3; s = s + 1) begin
        if (gsel_c[2*t +: 2] == s[1:0]) begin
          tx_v_c[t]           = src_v[s];
          tx_d_c[DW*t +: DW]  = src_d[DW*s +: DW];
          tx_l_c[t]           = src_l[s];
          src_rdy_c[s]        = tx_rdy[t];
        end
      end
    end
  end

  // a frame keeps its port and route until its last byte passes
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 3'h0;
      dst_q  <= 6'h00;
      own_q  <= {3{`SPS_SRC_NONE}};
    end else begin
      for (sq = 0; sq < 3; sq = sq + 1) begin
        if (src_v[sq] && src_rdy_c[sq]) begin
          busy_q[sq]       <= ~src_l[sq];
          dst_q[2*sq +: 2] <= dst_c[2*sq +: 2];
        end
      end
      for (tq = 0; tq < 3; tq = tq + 1) begin
        if (tx_v_c[tq] && tx_rdy[tq]) begin
          own_q[2*tq +: 2] <= tx_l_c[tq] ? `SPS_SRC_NONE : gsel_c[2*tq +: 2];
        end
      end
    end
  end

  // receive ready on the return ports follows the grant
  assign o_p1_rx_ready  = src_rdy_c[1];
  assign o_p2_rx_ready  = src_rdy_c[2];
  assign o_p0_tx_valid  = tx_v_c[0];
  assign o_p0_tx_data   = tx_d_c[DW-1:0];
  assign o_p0_tx_last   = tx_l_c[0];
  assign o_p1_tx_valid  = tx_v_c[1];
  assign o_p1_tx_data   = tx_d_c[2*DW-1:DW];
  assign o_p1_tx_last   = tx_l_c[1];
  assign o_p2_tx_valid  = tx_v_c[2];
  assign o_p2_tx_data   = tx_d_c[3*DW-1:2*DW];
  assign o_p2_tx_last   = tx_l_c[2];

  // status outputs
  assign o_outputs      = out_q;
  assign o_state        = (state_q == ST_COPY) ? ST_PREOP : state_q;
  assign o_ack          = ack_q;
  assign o_refused      = ref_q;
  assign o_mbx_en       = file_ok;
  assign o_pd_en        = pd_ok;
  assign o_frame_accept = acc_q;
  assign o_frame_reject = rej_q;

endmodule

`default_nettype wire

// ---- dv/sps_top_asserts.sv ----
// checker on state answers, traffic gating and frame classes of sps_top
`include "sps_regs.vh"
`default_nettype none
module sps_top_asserts #(
  parameter DW = 8
) (
  input wire logic          i_clk_sys,
  input wire logic          i_rst,
  input wire logic          i_p0_rx_valid,
  input wire logic [DW-1:0] i_p0_rx_data,
  input wire logic          i_p0_rx_last,
  input wire logic          o_p0_rx_ready,
  input wire logic          i_req_valid,
  input wire logic [3:0]    i_req_state,
  input wire logic          i_mbx_cfg_ok,
  input wire logic          i_pd_cfg_ok,
  input wire logic          i_dc_used,
  input wire logic          i_dc_cfg_ok,
  input wire logic          i_wdog_en,
  input wire logic [DW-1:0] o_outputs,
  input wire logic [3:0]    o_state,
  input wire logic          o_ack,
  input wire logic          o_refused,
  input wire logic          o_mbx_en,
  input wire logic          o_pd_en,
  input wire logic          o_frame_accept,
  input wire logic          o_frame_reject
);
  localparam logic [3:0] SI = `SPS_ST_INIT;
  localparam logic [3:0] SP = `SPS_ST_PREOP;
  localparam logic [3:0] SB = `SPS_ST_BOOT;
  localparam logic [3:0] SS = `SPS_ST_SAFEOP;
  localparam logic [3:0] SO = `SPS_ST_OP;
  logic sof_q;
  // next byte taken on port 0 opens a frame
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst)
      sof_q <= 1'b1;
    else if (i_p0_rx_valid && o_p0_rx_ready)
      sof_q <= i_p0_rx_last;
  end
  wire logic take0 = i_p0_rx_valid && o_p0_rx_ready && sof_q;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // a request in the copy cycle is excluded: preop is still shown then
  sequence s_to_safeop;
    i_req_valid && !$past(i_req_valid) && o_state == SP && i_req_state == SS
      && i_pd_cfg_ok && (!i_dc_used || i_dc_cfg_ok);
  endsequence
  sequence s_copy_ack;
    ##1 (o_state == SP && !o_ack) ##1 (o_ack && o_state == SS);
  endsequence
  AST_RST_INIT: assert property ($fell(i_rst) |-> o_state == SI && !o_mbx_en)
    else $error("state not init after reset");
  AST_INIT_GATE: assert property (o_state == SI |-> !o_mbx_en && !o_pd_en)
    else $error("traffic open in init");
  AST_PREOP_GATE: assert property (o_state == SP && !$past(i_req_valid) |-> o_mbx_en && !o_pd_en)
    else $error("wrong gating in preop");
  AST_BOOT_GATE: assert property (o_state == SB |-> o_mbx_en && !o_pd_en)
    else $error("wrong gating in boot");
  AST_RUN_GATE: assert property (o_state == SS || o_state == SO |-> o_mbx_en && o_pd_en)
    else $error("traffic closed in safeop or op");
  AST_BOOT_ENTRY: assert property ($changed(o_state) && o_state == SB |-> $past(o_state) == SI)
    else $error("boot entered from other than init");
  AST_REFUSE_STAY: assert property (i_req_valid && !$past(i_req_valid) && o_state != SI
    && o_state != SB && i_req_state == SB |=> o_refused && !o_ack && $stable(o_state))
    else $error("boot request not refused");
  AST_MBX_CHECK: assert property (i_req_valid && o_state == SI && i_req_state == SP
    |=> o_ack == $past(i_mbx_cfg_ok) && o_refused == !$past(i_mbx_cfg_ok))
    else $error("mailbox check wrong");
  AST_SAFEOP_ACK: assert property (s_to_safeop |-> s_copy_ack)
    else $error("safeop entry without copy cycle");
  AST_SAFE_OUT: assert property ((o_state == SS && i_wdog_en) ##1 o_state == SS
    |-> o_outputs == `SPS_SAFE_OUT)
    else $error("outputs not safe in safeop");
  AST_OBJ_REJECT: assert property (take0 && i_p0_rx_data == `SPS_TY_OBJ
    |=> o_frame_reject && !o_frame_accept)
    else $error("object dictionary frame not rejected");
  AST_PD_REJECT: assert property (take0 && i_p0_rx_data == `SPS_TY_PD && !o_pd_en
    |=> o_frame_reject)
    else $error("process data frame not rejected");
endmodule
bind sps_top sps_top_asserts #(.DW(DW)) sps_top_asserts_inst (.*);
`default_nettype wire

// ---- dv/sps_chain_model.sv ----
// terminal chain model behind port 1: returns every frame it receives
`default_nettype none
module sps_chain_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_stall,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_last,
  output var  logic       o_tx_ready,
  output var  logic       o_rx_valid,
  output var  logic [7:0] o_rx_data,
  output var  logic       o_rx_last,
  input  wire logic       i_rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] q [$];
  initial {o_tx_ready, o_rx_valid, o_rx_data, o_rx_last} = 11'h000;
  // changes only after the edge; idle data toggles so a stale byte never looks valid
  always @(posedge i_clk_sys) begin
    if (i_tx_valid && o_tx_ready)
      q.push_back({i_tx_last, i_tx_data});
    if (o_rx_valid && i_rx_ready)
      q.delete(0);
    o_tx_ready <= !i_stall;
    o_rx_valid <= q.size() != 0;
    o_rx_last <= q.size() != 0 && q[0][8];
    o_rx_data <= q.size() != 0 ? q[0][7:0] : ~o_rx_data;
  end
endmodule
`default_nettype wire

// ---- dv/sps_top_test.sv ----
// random and directed bench for the port ring and slave state machine
`include "sps_regs.vh"
`default_nettype none
module sps_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] SI = `SPS_ST_INIT, SP = `SPS_ST_PREOP, SB = `SPS_ST_BOOT;
  localparam logic [3:0] SS = `SPS_ST_SAFEOP, SO = `SPS_ST_OP;
  logic        i_clk_sys = 0, i_rst = 1, stall = 0, i_p0_tx_ready = 1, i_p2_tx_ready = 1;
  logic        i_p0_rx_valid = 0, i_p0_rx_last = 0, i_p2_rx_valid = 0, i_p2_rx_last = 0;
  logic [7:0]  i_p0_rx_data = 0, i_p2_rx_data = 0, i_inputs = 0;
  logic        i_p1_link = 0, i_p2_link = 0, i_req_valid = 0, i_mbx_cfg_ok = 0;
  logic        i_pd_cfg_ok = 0, i_dc_used = 0, i_dc_cfg_ok = 0, i_wdog_en = 1;
  logic [3:0]  i_req_state = 0, st = SI, o_state;
  logic        i_p1_rx_valid, i_p1_rx_last, i_p1_tx_ready, o_p0_rx_ready, o_p1_rx_ready;
  logic        o_p2_rx_ready, o_p0_tx_valid, o_p0_tx_last, o_p1_tx_valid, o_p1_tx_last;
  logic        o_p2_tx_valid, o_p2_tx_last, o_ack, o_refused, o_mbx_en, o_pd_en;
  logic        o_frame_accept, o_frame_reject;
  logic [7:0]  i_p1_rx_data, o_p0_tx_data, o_p1_tx_data, o_p2_tx_data, o_outputs, b1 [3];
  logic [31:0] rs = 32'h6f9b102f;
  logic [3:0]  codes [7] = '{SI, SP, SB, SS, SO, 4'h5, 4'h0};
  int          nb [3], pos [3], n0, n_acc, n_rej, n_mismatch, checks_done;
  sps_top #(.DW(8)) sps_top_inst (.*);
  sps_chain_model sps_chain_model_inst (.i_clk_sys(i_clk_sys), .i_stall(stall),
    .i_tx_valid(o_p1_tx_valid), .i_tx_data(o_p1_tx_data), .i_tx_last(o_p1_tx_last),
    .o_tx_ready(i_p1_tx_ready), .o_rx_valid(i_p1_rx_valid), .o_rx_data(i_p1_rx_data),
    .o_rx_last(i_p1_rx_last), .i_rx_ready(o_p1_rx_ready));
  always #2.5 i_clk_sys = ~i_clk_sys;
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // ready moves on the falling edge with the rest of the stimulus, settled at the rising edge
  always @(negedge i_clk_sys) begin
    i_p0_tx_ready <= rnd() % 4 != 0;
    i_p2_tx_ready <= rnd() % 4 != 0;
  end
  wire logic [2:0]  tv = {o_p2_tx_valid, o_p1_tx_valid, o_p0_tx_valid};
  wire logic [2:0]  tr = {i_p2_tx_ready, i_p1_tx_ready, i_p0_tx_ready};
  wire logic [2:0]  tl = {o_p2_tx_last, o_p1_tx_last, o_p0_tx_last};
  wire logic [23:0] td = {o_p2_tx_data, o_p1_tx_data, o_p0_tx_data};
  // count bytes leaving each port, keep the second byte of each frame
  always @(posedge i_clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (tv[i] && tr[i]) begin
        if (pos[i] == 1)
          b1[i] = td[8*i +: 8];
        nb[i]++;
        pos[i] = tl[i] ? 0 : pos[i] + 1;
      end
    end
    n0 += i_p0_rx_valid && o_p0_rx_ready;
    n_acc += o_frame_accept;
    n_rej += o_frame_reject;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic wait_nb(input int p, t);
    for (int w = 0; w < 3000 && nb[p] < t; w++)
      tick(1);
    chk(nb[p] >= t, 1, "bytes out");
  endtask
  function automatic logic ok_to(input logic [3:0] c, n);
    case (c)
      SI: return n == SI || n == SB || (n == SP && i_mbx_cfg_ok);
      SB: return n == SI || n == SB;
      SP: return n == SI || n == SP || (n == SS && i_pd_cfg_ok && (!i_dc_used || i_dc_cfg_ok));
      default: return n inside {SI, SP, SS, SO};
    endcase
  endfunction
  function automatic logic acc_of(input logic [7:0] cls);
    case (cls)
      `SPS_TY_MBX: return st inside {SP, SS, SO};
      `SPS_TY_FILE: return st inside {SP, SS, SO, SB};
      `SPS_TY_PD: return st inside {SS, SO};
      default: return 0;
    endcase
  endfunction
  task automatic req(input logic [3:0] n);
    logic ok;
    ok = ok_to(st, n);
    i_req_valid = 1;
    i_req_state = n;
    tick(1);
    i_req_valid = 0;
    if (ok && st == SP && n == SS) begin
      chk(o_state, SP, "copy cycle");
      tick(1);
    end
    chk(o_ack, ok, "ack");
    chk(o_refused, !ok, "refused");
    if (ok)
      st = n;
    chk(o_state, st, "state");
    chk(o_mbx_en, st != SI, "mailbox gate");
    chk(o_pd_en, st inside {SS, SO}, "pd gate");
    tick(1);
  endtask
  // holds each byte until the edge that takes it, then shows inverted data
  task automatic send(ref logic v, l, ref logic [7:0] d, ref logic rdy,
                      input logic [7:0] cls, b, input int len);
    for (int k = 0; k < len; k++) begin
      v = 1;
      d = k == 0 ? cls : k == 1 ? b : 8'(rnd());
      l = k == len - 1;
      #1;
      for (int w = 0; w < 500 && !rdy; w++)
        @(negedge i_clk_sys) #1;
      tick(1);
    end
    v = 0;
    d = ~d;
    l = 0;
  endtask
  task automatic s0(input logic [7:0] cls, b, input int len);
    send(i_p0_rx_valid, i_p0_rx_last, i_p0_rx_data, o_p0_rx_ready, cls, b, len);
  endtask
  // both links up: a processed frame returns through the chain to port 2
  task automatic frame(input logic [7:0] cls, b);
    int a, r, t;
    a = n_acc;
    r = n_rej;
    t = nb[2] + 6;
    s0(cls, b, 6);
    wait_nb(2, t);
    chk(n_acc - a, acc_of(cls), "accept");
    chk(n_rej - r, cls != 8'h00 && cls <= 8'h04 && !acc_of(cls), "reject");
  endtask
  // roughly a thousand cycles of work; the limit of forty thousand cycles lies far above that
  initial begin
    #200us;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    int ex [3], t, fin;
    logic [31:0] r;
    logic [7:0] x;
    tick(8);
    i_rst = 0;
    chk(o_state, SI, "reset state");
    chk(o_outputs, `SPS_SAFE_OUT, "reset outputs");
    for (int c = 0; c < 4; c++) begin
      {i_p2_link, i_p1_link} = c[1:0];
      tick(4);
      ex = nb;
      fin = c[1] ? 2 : 0;
      ex[fin] += 8;
      if (c[0])
        ex[1] += 8;
      s0(`SPS_TY_MBX, 8'h5a, 8);
      wait_nb(fin, ex[fin]);
      for (int p = 0; p < 3; p++)
        chk(nb[p], ex[p], "route");
    end
    t = nb[0] + 5;
    send(i_p2_rx_valid, i_p2_rx_last, i_p2_rx_data, o_p2_rx_ready, 8'h01, 8'h22, 5);
    wait_nb(0, t);
    stall = 1;
    t = n0;
    fork
      s0(`SPS_TY_MBX, 8'h11, 40);
    join_none
    tick(60);
    chk(n0 - t, `SPS_FIFO_DEPTH, "fill level");
    chk(o_p0_rx_ready, 0, "full refuses");
    t = nb[2] + 40;
    stall = 0;
    wait_nb(2, t);
    req(SB);
    frame(`SPS_TY_FILE, 8'h01);
    frame(`SPS_TY_MBX, 8'h02);
    frame(`SPS_TY_PD, 8'h03);
    req(SP);
    req(SI);
    req(SP);
    i_mbx_cfg_ok = 1;
    req(SP);
    req(SB);
    frame(`SPS_TY_PD, 8'h04);
    frame(`SPS_TY_MBX, 8'h05);
    frame(`SPS_TY_OBJ, 8'h06);
    req(SS);
    i_pd_cfg_ok = 1;
    i_dc_used = 1;
    req(SS);
    i_dc_cfg_ok = 1;
    req(SS);
    i_inputs = 8'(rnd());
    x = 8'(rnd());
    frame(`SPS_TY_PD, x);
    chk(b1[2], i_inputs, "input image");
    chk(o_outputs, `SPS_SAFE_OUT, "safe outputs");
    i_wdog_en = 0;
    tick(2);
    chk(o_outputs, x, "unguarded outputs");
    x = ~x;
    frame(`SPS_TY_PD, x);
    req(SO);
    i_wdog_en = 1;
    tick(2);
    chk(o_outputs, x, "op outputs");
    repeat (40) begin
      r = rnd();
      {i_dc_cfg_ok, i_dc_used, i_pd_cfg_ok, i_mbx_cfg_ok} = r[3:0];
      i_inputs = r[23:16];
      req(codes[r[10:8] % 7]);
      if (r[5])
        frame(8'(r[25:24]) + 8'h01, r[15:8]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
